// ### fir_defines.vh
// constants shared by the filter control files
`ifndef FIR_DEFINES_VH
`define FIR_DEFINES_VH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define DATA_W 8
`define COEF_W 8
`define PROD_W 16
`define ACC_W 18
`define TAPS 4
`define TAP_W 2
`define NUM_SETS 2
`define SET_W 1
`define NUM_CH 2
`define CH_W 1
`define CNT_W 4
`define WM_W 8

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_CONFIG 8'h04
`define REG_STATUS 8'h08

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_SRST 1
`define CTRL_STREAM 2
`define CTRL_IN_ADAPT 3
`define CTRL_OUT_ADAPT 4
`define CTRL_ARCH_LO 5
`define CTRL_ARCH_HI 6
`define CFG_UNITS_LO 0
`define CFG_UNITS_HI 1
`define CFG_CYC_LO 8
`define CFG_CYC_HI 11
`define CFG_WM_LO 16
`define CFG_WM_HI 23

// ---------------------------------------------------------------
// reset values, structure codes, timing counts
// ---------------------------------------------------------------
`define CTRL_RST 32'h00000000
`define CFG_RST 32'h00040401
`define ARCH_PAR 2'h0
`define ARCH_SER 2'h1
`define ARCH_MBS 2'h2
`define ARCH_MCV 2'h3
`define CPR_PAR 4'h1
`define CPR_SERIAL 4'h8

`endif

// ### level_sync.v
// two flip-flop synchroniser for a group of slow levels
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter W = 1
) (
  // clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire en,
  // levels
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (en) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // level_sync

`default_nettype wire

// ### sample_history.v
// per-channel delay line of past input samples, never reset
`timescale 1ns/1ps
`default_nettype none
`include "fir_defines.vh"

module sample_history (
  // clock and enable
  input wire clk,
  input wire en,
  // write side
  input wire shift,
  input wire [`CH_W-1:0] wr_ch,
  input wire [`DATA_W-1:0] din,
  // read side
  input wire [`CH_W-1:0] rd_ch,
  output reg [`TAPS*`DATA_W-1:0] taps
);

  reg [`DATA_W-1:0] mem [0:`NUM_CH*`TAPS-1];
  integer i;
  integer j;

  // past samples hold through reset; flushing is done with zeros
  always @(posedge clk) begin
    if (en && shift) begin
      mem[wr_ch*`TAPS] <= din;
      for (i = 1; i < `TAPS; i = i + 1) begin
        mem[wr_ch*`TAPS+i] <= mem[wr_ch*`TAPS+i-1];
      end
    end
  end

  always @* begin
    taps = {`TAPS*`DATA_W{1'b0}};
    for (j = 0; j < `TAPS; j = j + 1) begin
      taps[j*`DATA_W +: `DATA_W] = mem[rd_ch*`TAPS+j];
    end
  end

endmodule // sample_history

`default_nettype wire

// ### fir_filter_stream_interface.v
// control, stream interface and register slave of the fir filter
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fir_defines.vh"

module fir_filter_stream_interface (
  // clock, reset, clock gate
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // plain sample interface
  input wire [`DATA_W-1:0] sample_in,
  input wire [`SET_W-1:0] coef_set_select,
  output wire input_accept_ready,
  output wire done,
  output wire [`ACC_W-1:0] fir_result,
  output wire [`CH_W-1:0] input_channel_index,
  output wire [`CH_W-1:0] result_channel_index,
  // coefficient reload, on its own clock
  input wire coef_load_clk,
  input wire coef_we,
  input wire [`SET_W-1:0] coef_write_set,
  input wire [`COEF_W-1:0] coef_value,
  output wire coefficient_load_strobe,
  // stream input, filter pulls from an upstream source, or takes pushed words when CTRL_IN_ADAPT is set
  input wire sink_dav,
  input wire sink_val,
  input wire sink_sop,
  input wire sink_eop,
  input wire [`SET_W+`DATA_W-1:0] sink_dat,
  output wire sink_ena,
  // stream output, filter pushes into a downstream sink
  input wire source_dav,
  output wire source_ena,
  output wire source_sop,
  output wire source_eop,
  output wire [`ACC_W-1:0] source_dat
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam CS_W = 2 + `SET_W + `COEF_W;
  localparam [31:0] CTRL_RST_V = `CTRL_RST;
  localparam [31:0] CFG_RST_V = `CFG_RST;

  reg run_q, srst_q, stream_q, in_adapt_q, out_adapt_q;
  reg [1:0] arch_q;
  reg [1:0] units_q;
  reg [3:0] cyc_q;
  reg [`WM_W-1:0] wm_q;
  reg [31:0] prdata_q;
  reg pready_q, pslverr_q;

  reg [`CNT_W-1:0] cnt_q, cnt_d, cpr;
  reg pend_q, ready_q, done_q;
  reg [`ACC_W-1:0] result_q;
  reg [`CH_W-1:0] in_ch_q, res_ch_q, out_ch_q;
  reg [`SET_W-1:0] res_set_q;
  reg [`WM_W-1:0] wcnt_q;
  reg sink_ena_q, src_ena_q, src_sop_q, src_eop_q;
  reg in_pkt_q;

  reg [`COEF_W-1:0] coef_mem [0:`NUM_SETS*`TAPS-1];
  reg [`TAP_W-1:0] caddr_q;
  reg ck_prev_q, we_prev_q, cstrobe_q;

  wire [CS_W-1:0] cs_q;
  wire ck_s, we_s;
  wire [`SET_W-1:0] wset_s;
  wire [`COEF_W-1:0] cval_s;
  wire [`TAPS*`DATA_W-1:0] taps;
  wire active, take, src_ok, emit, pend_d, ready_d, stall;
  wire [`DATA_W-1:0] sample_w;
  wire [`SET_W-1:0] set_w;
  wire [`CH_W-1:0] take_ch;
  wire setup, access, mapped, clk_fall, we_rise;

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_CONFIG) ||
                  (paddr == `REG_STATUS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      run_q <= CTRL_RST_V[`CTRL_RUN];
      srst_q <= CTRL_RST_V[`CTRL_SRST];
      stream_q <= CTRL_RST_V[`CTRL_STREAM];
      in_adapt_q <= CTRL_RST_V[`CTRL_IN_ADAPT];
      out_adapt_q <= CTRL_RST_V[`CTRL_OUT_ADAPT];
      arch_q <= CTRL_RST_V[`CTRL_ARCH_HI:`CTRL_ARCH_LO];
      units_q <= CFG_RST_V[`CFG_UNITS_HI:`CFG_UNITS_LO];
      cyc_q <= CFG_RST_V[`CFG_CYC_HI:`CFG_CYC_LO];
      wm_q <= CFG_RST_V[`CFG_WM_HI:`CFG_WM_LO];
    end else if (clk_en) begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !mapped || (pwrite && paddr == `REG_STATUS);
        case (paddr)
          `REG_CTRL: prdata_q <= {25'h0000000, arch_q, out_adapt_q,
                                  in_adapt_q, stream_q, srst_q, run_q};
          `REG_CONFIG: prdata_q <= {8'h00, wm_q, 4'h0, cyc_q, 6'h00,
                                    units_q};
          `REG_STATUS: prdata_q <= {22'h000000, in_pkt_q, out_ch_q,
                                    in_ch_q, cnt_q, stall, pend_q,
                                    ready_q};
          default: prdata_q <= 32'h00000000;
        endcase
      end else if (access) begin
        pslverr_q <= 1'b0;
      end
      if (access && pwrite && paddr == `REG_CTRL) begin
        run_q <= pwdata[`CTRL_RUN];
        srst_q <= pwdata[`CTRL_SRST];
        stream_q <= pwdata[`CTRL_STREAM];
        in_adapt_q <= pwdata[`CTRL_IN_ADAPT];
        out_adapt_q <= pwdata[`CTRL_OUT_ADAPT];
        arch_q <= pwdata[`CTRL_ARCH_HI:`CTRL_ARCH_LO];
      end
      if (access && pwrite && paddr == `REG_CONFIG) begin
        units_q <= pwdata[`CFG_UNITS_HI:`CFG_UNITS_LO];
        cyc_q <= pwdata[`CFG_CYC_HI:`CFG_CYC_LO];
        wm_q <= pwdata[`CFG_WM_HI:`CFG_WM_LO];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------
  // cycles per result for the chosen structure
  // ---------------------------------------------------------------
  always @* begin
    case (arch_q)
      `ARCH_PAR: cpr = `CPR_PAR;
      `ARCH_SER: cpr = `CPR_SERIAL;
      `ARCH_MBS: cpr = `CPR_SERIAL >> units_q;
      `ARCH_MCV: cpr = (cyc_q == 4'h0) ? `CPR_PAR : cyc_q;
      default: cpr = `CPR_PAR;
    endcase
  end

  // ---------------------------------------------------------------
  // sample acceptance and result sequencing
  // ---------------------------------------------------------------
  assign active = run_q && !srst_q;
  // a pulled word counts when pull was high last edge and word is present
  assign take = active && (stream_q ?
                (in_adapt_q ? (sink_val && ready_q)
                            : (sink_ena_q && sink_val))
                : ready_q);
  assign sample_w = stream_q ? sink_dat[`DATA_W-1:0] : sample_in;
  assign set_w = stream_q ? sink_dat[`DATA_W +: `SET_W]
                          : coef_set_select;
  assign take_ch = (stream_q && sink_sop) ? {`CH_W{1'b0}} : in_ch_q;

  assign src_ok = out_adapt_q || source_dav;
  assign emit = pend_q && cnt_q == {`CNT_W{1'b0}} &&
                (!stream_q || src_ok);
  assign stall = pend_q && cnt_q == {`CNT_W{1'b0}} && !emit;
  assign pend_d = take || (pend_q && !emit);
  // a pulled word cannot be refused, so pull only into an empty slot
  assign ready_d = active && cnt_d == {`CNT_W{1'b0}} &&
                   !(stream_q && pend_d && !out_adapt_q);

  always @* begin
    if (take) begin
      cnt_d = cpr - `CPR_PAR;
    end else if (cnt_q != {`CNT_W{1'b0}}) begin
      cnt_d = cnt_q - `CPR_PAR;
    end else begin
      cnt_d = {`CNT_W{1'b0}};
    end
  end

  sample_history u_history (
    .clk(pclk),
    .en(clk_en),
    .shift(take),
    .wr_ch(take_ch),
    .din(sample_w),
    .rd_ch(res_ch_q),
    .taps(taps)
  );

  // ---------------------------------------------------------------
  // multiply-accumulate over the taps of one channel
  // ---------------------------------------------------------------
  reg signed [`ACC_W-1:0] acc;
  reg signed [`PROD_W-1:0] prod;
  integer k;

  always @* begin
    acc = {`ACC_W{1'b0}};
    prod = {`PROD_W{1'b0}};
    for (k = 0; k < `TAPS; k = k + 1) begin
      prod = $signed(coef_mem[{res_set_q, k[`TAP_W-1:0]}]) *
             $signed(taps[k*`DATA_W +: `DATA_W]);
      acc = acc + {{(`ACC_W-`PROD_W){prod[`PROD_W-1]}}, prod};
    end
  end

  // ---------------------------------------------------------------
  // control state; the soft reset clears all but result_q, res_ch_q and res_set_q, never the samples
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {`CNT_W{1'b0}};
      pend_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= {`ACC_W{1'b0}};
      in_ch_q <= {`CH_W{1'b0}};
      res_ch_q <= {`CH_W{1'b0}};
      out_ch_q <= {`CH_W{1'b0}};
      res_set_q <= {`SET_W{1'b0}};
      wcnt_q <= {`WM_W{1'b0}};
      sink_ena_q <= 1'b0;
      src_ena_q <= 1'b0;
      src_sop_q <= 1'b0;
      src_eop_q <= 1'b0;
      in_pkt_q <= 1'b0;
    end else if (clk_en) begin
      if (srst_q) begin
        cnt_q <= {`CNT_W{1'b0}};
        pend_q <= 1'b0;
        ready_q <= 1'b0;
        done_q <= 1'b0;
        in_ch_q <= {`CH_W{1'b0}};
        out_ch_q <= {`CH_W{1'b0}};
        wcnt_q <= {`WM_W{1'b0}};
        sink_ena_q <= 1'b0;
        src_ena_q <= 1'b0;
        src_sop_q <= 1'b0;
        src_eop_q <= 1'b0;
        in_pkt_q <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        pend_q <= pend_d;
        ready_q <= ready_d;
        // pull only while the upstream source offers words
        sink_ena_q <= stream_q && !in_adapt_q && sink_dav &&
                      ready_d;
        if (take) begin
          res_ch_q <= take_ch;
          res_set_q <= set_w;
          if (take_ch == `NUM_CH - 1) begin
            in_ch_q <= {`CH_W{1'b0}};
          end else begin
            in_ch_q <= take_ch + 1'b1;
          end
          if (stream_q && sink_sop) begin
            in_pkt_q <= 1'b1;
          end
          if (stream_q && sink_eop) begin
            in_pkt_q <= 1'b0;
          end
        end
        done_q <= emit;
        // word, framing and strobe all leave on the same edge
        src_ena_q <= emit && stream_q;
        src_sop_q <= emit && stream_q &&
                     wcnt_q == {`WM_W{1'b0}};
        src_eop_q <= emit && stream_q &&
                     (wcnt_q + 1'b1 >= wm_q);
        if (emit) begin
          result_q <= acc;
          out_ch_q <= res_ch_q;
          if (stream_q) begin
            if (wcnt_q + 1'b1 >= wm_q) begin
              wcnt_q <= {`WM_W{1'b0}};
            end else begin
              wcnt_q <= wcnt_q + 1'b1;
            end
          end
        end
      end
    end
  end

  assign input_accept_ready = ready_q;
  assign done = done_q;
  assign fir_result = result_q;
  assign input_channel_index = in_ch_q;
  assign result_channel_index = out_ch_q;
  assign sink_ena = sink_ena_q;
  assign source_ena = src_ena_q;
  assign source_sop = src_sop_q;
  assign source_eop = src_eop_q;
  assign source_dat = result_q;

  // ---------------------------------------------------------------
  // coefficient reload from the coefficient clock domain
  // ---------------------------------------------------------------
  level_sync #(
    .W(CS_W)
  ) u_coef_sync (
    .clk(pclk),
    .rst_n(presetn),
    .en(clk_en),
    .d({coef_load_clk, coef_we, coef_write_set, coef_value}),
    .q(cs_q)
  );

  assign ck_s = cs_q[CS_W-1];
  assign we_s = cs_q[CS_W-2];
  assign wset_s = cs_q[`COEF_W +: `SET_W];
  assign cval_s = cs_q[`COEF_W-1:0];
  // values change on the rising reload edge, so take them on the falling
  assign clk_fall = ck_prev_q && !ck_s;
  assign we_rise = we_s && !we_prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_prev_q <= 1'b0;
      we_prev_q <= 1'b0;
      caddr_q <= {`TAP_W{1'b0}};
      cstrobe_q <= 1'b0;
    end else if (clk_en) begin
      ck_prev_q <= ck_s;
      we_prev_q <= we_s;
      cstrobe_q <= we_s && clk_fall && arch_q == `ARCH_MCV;
      if (we_rise) begin
        caddr_q <= {`TAP_W{1'b0}};
      end else if (we_s && clk_fall) begin
        caddr_q <= caddr_q + 1'b1;
      end
    end
  end

  always @(posedge pclk) begin
    if (clk_en && we_s && !we_rise && clk_fall) begin
      coef_mem[{wset_s, caddr_q}] <= cval_s;
    end
  end

  assign coefficient_load_strobe = cstrobe_q;

endmodule // fir_filter_stream_interface

`default_nettype wire

// ### fir_stream_checker.sv
// port assertions for the filter control block
`timescale 1ns/1ps
`default_nettype none
`include "fir_defines.vh"

module fir_stream_checker (
  // clock, reset, gate
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // filter outputs
  input wire logic done,
  input wire logic [`ACC_W-1:0] fir_result,
  input wire logic input_accept_ready,
  input wire logic [`CH_W-1:0] input_channel_index,
  // stream
  input wire logic sink_dav,
  input wire logic sink_ena,
  input wire logic source_dav,
  input wire logic source_ena,
  input wire logic source_sop,
  input wire logic source_eop
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_gate_freeze: assert property (
    !clk_en |=> $stable({done, fir_result, input_accept_ready,
      input_channel_index, sink_ena, source_ena, pready, prdata}))
    else $error("outputs moved while the gate was low");
  chk_source_stop: assert property (
    (!source_dav && clk_en) [*2] |-> !source_ena)
    else $error("transfer strobe held without downstream space");
  chk_sop_strobe: assert property (source_sop |-> source_ena)
    else $error("packet start without transfer strobe");
  chk_eop_strobe: assert property (source_eop |-> source_ena)
    else $error("packet end without transfer strobe");
  chk_pull_release: assert property (
    !sink_dav && clk_en |=> !sink_ena)
    else $error("pull strobe held after source emptied");
  chk_reset_quiet: assert property ($rose(presetn) |->
    !done && !sink_ena && !source_ena && !input_accept_ready)
    else $error("outputs not cleared by reset");
  chk_bus_answer: assert property (psel && !penable && clk_en |=> pready)
    else $error("bus answer not in first access cycle");
  chk_ready_pulse: assert property (pready && clk_en |=> !pready)
    else $error("bus answer longer than one cycle");
  chk_error_pair: assert property (pslverr |-> pready)
    else $error("bus error without answer");

  cov_word_out: cover property (source_ena && source_eop);
  cov_gate: cover property (!clk_en ##1 !clk_en);
  cov_refused: cover property (pready && pslverr);
endmodule // fir_stream_checker
`default_nettype wire

// ### stream_partner.sv
// upstream slave source and downstream slave sink model
`timescale 1ns/1ps
`default_nettype none
`include "fir_defines.vh"

module stream_partner #(
  parameter int N_WORDS = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench controls
  input wire logic offer,
  input wire logic hold,
  input wire logic room,
  input wire logic [`SET_W-1:0] word_set,
  // upstream source
  input wire logic sink_ena,
  output logic sink_dav,
  output logic sink_val,
  output logic sink_sop,
  output logic sink_eop,
  output logic [`SET_W+`DATA_W-1:0] sink_dat,
  // downstream sink
  output logic source_dav,
  input wire logic source_ena,
  input wire logic source_sop,
  input wire logic source_eop,
  input wire logic [`ACC_W-1:0] source_dat,
  // tallies
  output int n_words,
  output int n_sops,
  output int n_eops,
  output logic [`ACC_W-1:0] last_dat
);
  int idx;
  logic [`SET_W+`DATA_W-1:0] word;

  // set selection packed above the sample
  assign word = {word_set, 8'h03};
  assign sink_dav = offer && idx < N_WORDS;
  // word answers the pull strobe at once; hold makes it slow
  assign sink_val = sink_ena && !hold && idx < N_WORDS;
  assign sink_sop = sink_val ? idx % 4 == 0 : 1'b1;
  assign sink_eop = sink_val ? idx % 4 == 3 : 1'b1;
  // idle bus shows the inverse of the word
  assign sink_dat = sink_val ? word : ~word;
  assign source_dav = room;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx <= 0;
      n_words <= 0;
      n_sops <= 0;
      n_eops <= 0;
      last_dat <= '0;
    end else begin
      if (sink_ena && sink_val)
        idx <= idx + 1;
      // words framed by the strobe are kept; the bus between them is ignored
      if (source_ena) begin
        n_words <= n_words + 1;
        n_sops <= n_sops + int'(source_sop);
        n_eops <= n_eops + int'(source_eop);
        last_dat <= source_dat;
      end
    end
  end
endmodule // stream_partner
`default_nettype wire

// ### testbench.sv
// self-checking bench for the filter control block
`timescale 1ns/1ps
`default_nettype none
`include "fir_defines.vh"

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
  n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
  logic pclk = 0, presetn = 0, clk_en = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rdata;
  wire [31:0] prdata;
  wire pready, pslverr, input_accept_ready, done, coefficient_load_strobe;
  logic [`DATA_W-1:0] sample_in = 0;
  logic [`SET_W-1:0] coef_set_select = 0, coef_write_set = 0, word_set = 0;
  wire [`ACC_W-1:0] fir_result, source_dat;
  wire [`CH_W-1:0] input_channel_index, result_channel_index;
  logic coef_load_clk = 0, coef_we = 0, offer = 0, hold = 0, room = 0;
  logic [`COEF_W-1:0] coef_value = 0;
  wire sink_dav, sink_val, sink_sop, sink_eop, sink_ena;
  wire [`SET_W+`DATA_W-1:0] sink_dat;
  wire source_dav, source_ena, source_sop, source_eop;
  int n_words, n_sops, n_eops, n_errors = 0, checked = 0;
  int n_strobes = 0;
  logic [`ACC_W-1:0] last_dat;
  logic rerr;
  logic [`CH_W-1:0] idx;
  logic [31:0] arch_ctrl [4] = '{32'h00000001, 32'h00000021,
    32'h00000041, 32'h00000061};
  int arch_cpr [4] = '{1, 8, 4, 4};

  fir_filter_stream_interface DUT (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sample_in, .coef_set_select, .input_accept_ready, .done, .fir_result,
    .input_channel_index, .result_channel_index, .coef_load_clk, .coef_we,
    .coef_write_set, .coef_value, .coefficient_load_strobe, .sink_dav,
    .sink_val, .sink_sop, .sink_eop, .sink_dat, .sink_ena, .source_dav,
    .source_ena, .source_sop, .source_eop, .source_dat);
  stream_partner partner (.pclk, .presetn, .offer, .hold, .room, .word_set,
    .sink_ena, .sink_dav, .sink_val, .sink_sop, .sink_eop, .sink_dat,
    .source_dav, .source_ena, .source_sop, .source_eop, .source_dat,
    .n_words, .n_sops, .n_eops, .last_dat);

  initial forever #20 pclk = ~pclk;

  always @(posedge pclk) begin
    if (coefficient_load_strobe === 1'b1)
      n_strobes++;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (done !== 1'b1 && n < 100);
    `CHK(done, 1'b1);
  endtask

  task automatic coef_load(input logic s, input logic [7:0] v);
    coef_write_set <= s;
    coef_value <= v;
    repeat (4) @(posedge pclk);
    coef_we <= 1'b1;
    repeat (8) @(posedge pclk);
    repeat (2 * `TAPS) begin
      coef_load_clk <= ~coef_load_clk;
      repeat (4) @(posedge pclk);
    end
    coef_we <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic summarize();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    summarize();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rdata, `CTRL_RST);
    apb(1'b0, `REG_CONFIG, 32'h0);
    `CHK(rdata, `CFG_RST);
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(rerr, 1'b1);
    apb(1'b1, `REG_STATUS, 32'hFFFFFFFF);
    `CHK(rerr, 1'b1);
    coef_load(1'b0, 8'h01);
    coef_load(1'b1, 8'h02);
    `CHK(n_strobes, 0);
    apb(1'b1, `REG_CTRL, 32'h00000001);
    repeat (10) @(posedge pclk);
    sample_in <= 8'h03;
    repeat (10) @(posedge pclk);
    wait_done();
    `CHK(fir_result, 18'h0000C);
    `CHK(input_accept_ready, 1'b1);
    idx = result_channel_index;
    @(posedge pclk);
    `CHK(done, 1'b1);
    `CHK(result_channel_index, ~idx);
    coef_set_select <= 1'b1;
    repeat (3) @(posedge pclk);
    wait_done();
    `CHK(fir_result, 18'h00018);
    clk_en <= 1'b0;
    @(posedge pclk);
    idx = input_channel_index;
    repeat (3) @(posedge pclk);
    `CHK(input_channel_index, idx);
    clk_en <= 1'b1;
    apb(1'b1, `REG_CTRL, 32'h00000003);
    repeat (2) @(posedge pclk);
    `CHK(input_accept_ready, 1'b0);
    `CHK(input_channel_index, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h00000001);
    wait_done();
    `CHK(fir_result, 18'h00018);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `REG_CTRL, arch_ctrl[i]);
      wait_done();
      wait_done();
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (done !== 1'b1 && n < 50);
      `CHK(n, arch_cpr[i]);
      `CHK(fir_result, 18'h00018);
    end
    coef_load(1'b1, 8'h02);
    `CHK(n_strobes, `TAPS);
    apb(1'b1, `REG_CTRL, 32'h00000002);
    apb(1'b1, `REG_CTRL, 32'h00000005);
    word_set <= 1'b1;
    offer <= 1'b1;
    room <= 1'b1;
    repeat (6) begin
      @(posedge pclk);
      hold <= ~hold;
    end
    room <= 1'b0;
    repeat (6) @(posedge pclk);
    room <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (n_words < 8 && n < 300);
    repeat (4) @(posedge pclk);
    `CHK(n_words, 8);
    `CHK(n_sops, 2);
    `CHK(n_eops, 2);
    `CHK(last_dat, 18'h00018);
    summarize();
  end
endmodule // testbench

bind fir_filter_stream_interface fir_stream_checker chk_i (.pclk, .presetn,
  .clk_en, .psel, .penable, .prdata, .pready, .pslverr, .done, .fir_result,
  .input_accept_ready, .input_channel_index, .sink_dav, .sink_ena,
  .source_dav, .source_ena, .source_sop, .source_eop);
`default_nettype wire
